// ==== rtl/swl_pkg.sv ====
// shared constants and types for the sextet wiper serial loader
package swl_pkg;

    // shift register and field geometry
    localparam int SWL_POTS = 6;
    localparam int SWL_FIELD_W = 8;
    localparam int SWL_POS_W = 6;
    localparam int SWL_SR_W = 48;
    localparam int SWL_KEEP_HI = 7;
    localparam int SWL_KEEP_LO = 6;
    localparam logic [1:0] SWL_KEEP_CODE = 2'h3;
    localparam logic [5:0] SWL_LAST_BIT = 6'h2F;
    localparam logic [5:0] SWL_CNT_ONE = 6'h01;

    // values after reset
    localparam logic [5:0] SWL_POS_RESET = 6'h00;
    localparam logic [47:0] SWL_SR_RESET = 48'h0000_0000_0000;
    localparam logic [5:0] SWL_CNT_RESET = 6'h00;

    // link timing, figures in ns, counts in core cycles
    localparam int SWL_CORE_NS = 40;
    localparam int SWL_T_CC_NS = 50;
    localparam int SWL_T_HLT_NS = 50;
    localparam int SWL_T_RLT_NS = 125;
    localparam logic [7:0] SWL_CC_CYC =
        8'((SWL_T_CC_NS + SWL_CORE_NS - 1) / SWL_CORE_NS);
    localparam logic [7:0] SWL_HLT_CYC =
        8'((SWL_T_HLT_NS + SWL_CORE_NS - 1) / SWL_CORE_NS);
    localparam logic [7:0] SWL_RLT_CYC =
        8'((SWL_T_RLT_NS + SWL_CORE_NS - 1) / SWL_CORE_NS);
    localparam int SWL_HALF_CYC = 4;

    // controller register offsets on APB
    localparam logic [7:0] SWL_REG_CTRL = 8'h00;
    localparam logic [7:0] SWL_REG_STATUS = 8'h04;
    localparam logic [7:0] SWL_REG_TXLO = 8'h08;
    localparam logic [7:0] SWL_REG_TXHI = 8'h0C;
    localparam logic [7:0] SWL_REG_RXLO = 8'h10;
    localparam logic [7:0] SWL_REG_RXHI = 8'h14;
    localparam int SWL_CTRL_START = 0;
    localparam int SWL_CTRL_READ = 1;

    // controller sequencer states
    typedef enum logic [2:0] {
        SWL_IDLE = 3'b000,
        SWL_ENSETUP = 3'b001,
        SWL_CLKLOW = 3'b010,
        SWL_CLKHIGH = 3'b011,
        SWL_ENDHOLD = 3'b100,
        SWL_RECOVER = 3'b101
    } swl_host_e;

endpackage

// ==== rtl/swl_link_if.sv ====
// three-wire link with cascade feedback between controller and device
interface swl_link_if;
    logic txnEn;
    logic shiftClk;
    logic hostData;
    logic hostDataOeN;
    logic cascade;
    logic serData;

    // released data line is pulled to cascade through the feedback path
    assign serData = hostDataOeN ? cascade : hostData;

    modport host (
        output txnEn,
        output shiftClk,
        output hostData,
        output hostDataOeN,
        input cascade
    );
    modport dev (
        input txnEn,
        input shiftClk,
        input serData,
        output cascade
    );
endinterface

// ==== rtl/swl_device.sv ====
// device end: 48-bit serial shift register and six wiper positions
// The shift register lives on the link's shift clock.  The wiper bank
// lives on core_clk and learns of the end of a frame through a two
// flop synchroniser on the enable.  Once the enable is low the shift
// clock carries no accepted edges, so the shift register is static
// when the core domain copies it.
//
// Hazards and limits:
// The copy into the wiper bank is a 48-bit crossing with no handshake.
// It is safe because the copy happens three or four core cycles after
// the enable falls, while a well-behaved controller keeps the shift
// clock parked and waits its recovery time before the next frame.  A
// controller that starts a new frame sooner could race the copy.
// A cut frame is applied as it stands, so its fields mix old and new
// bits; partialTxn flags it at that apply so software can rewrite.
// The link side has no reset synchroniser of its own: nrst clears the
// shift register at once, cascade drops with it, and release is safe
// because the shift clock is parked whenever the port is idle.
// In a chain each device still counts only its own 48 bits, so the
// flag only sees frames that are not a whole multiple of 48.
// Keep-coded fields stay in the shift register, so a recirculating
// read hands the same codes back and leaves those wipers alone too.
//
// Frame walk, seen from the core clock: the enable rises, 48 shift
// clock rises fill the register, the enable falls, two flops later the
// fall is seen, and one edge after that wipers, mask and flag move
// together with applyPulse.
module swl_device
    import swl_pkg::*;
(
    // core clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // link to the controller
    swl_link_if.dev link,
    // wiper positions, pot 1 at index 0
    output logic [SWL_POTS-1:0][SWL_POS_W-1:0] wiperPos,
    // status of the last applied frame
    output logic applyPulse,
    output logic [SWL_POTS-1:0] keptMask,
    output logic partialTxn,
    // port activity seen from the core side
    output logic txnActive
);

    // link domain state
    typedef struct packed {
        // stage 47 drives cascade, stage 0 takes the data line
        logic [SWL_SR_W-1:0] shiftReg;
        // bits seen so far, modulo one device's 48
        logic [5:0] bitCnt;
    } swl_dlink_s;

    // core domain state
    typedef struct packed {
        // enable synchroniser and the edge memory behind it
        logic enMeta;
        logic enSync;
        logic enPrev;
        // registered copies of the outputs
        logic [SWL_POTS-1:0][SWL_POS_W-1:0] wiperPos;
        logic applyPulse;
        logic [SWL_POTS-1:0] keptMask;
        logic partialTxn;
        // bit count at the previous apply
        logic [5:0] lastCnt;
    } swl_dcore_s;

    swl_dlink_s lk;
    swl_dlink_s next_lk;
    swl_dcore_s cs;
    swl_dcore_s next_cs;

    // pick one 8-bit field; pot 0 bit 0 sits in the last stage
    function automatic logic [SWL_FIELD_W-1:0] fieldOf(
        input logic [SWL_SR_W-1:0] sr,
        input int pot
    );
        logic [SWL_FIELD_W-1:0] f;
        f = '0;
        // stages count down since bits enter at stage 0
        for (int b = 0; b < SWL_FIELD_W; b++) begin
            f[b] = sr[SWL_SR_W - 1 - (pot * SWL_FIELD_W + b)];
        end
        return f;
    endfunction

    // true when the field asks to leave the wiper alone
    function automatic logic isKeep(input logic [SWL_FIELD_W-1:0] f);
        return f[SWL_KEEP_HI:SWL_KEEP_LO] == SWL_KEEP_CODE;
    endfunction

    // shift stage, next value
    always_comb begin
        // a refused edge leaves register and count as they were
        next_lk = lk;
        if (link.txnEn) begin
            // earliest bit ends in last stage
            next_lk.shiftReg = {lk.shiftReg[SWL_SR_W-2:0], link.serData};
            // bit count modulo 48 flags short frames
            if (lk.bitCnt == SWL_LAST_BIT) begin
                next_lk.bitCnt = SWL_CNT_RESET;
            end else begin
                next_lk.bitCnt = lk.bitCnt + SWL_CNT_ONE;
            end
        end
    end

    // shift stage registers on the link clock
    always_ff @(posedge link.shiftClk or negedge nrst) begin
        if (!nrst) begin
            // async clear with no edge; cascade drops at once
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    // fed back, it recirculates the register
    assign link.cascade = lk.shiftReg[SWL_SR_W-1];

    // core side, next value
    always_comb begin
        logic endOfTxn;
        logic [SWL_FIELD_W-1:0] f;
        // helpers start at zero so no latch is inferred
        endOfTxn = 1'b0;
        f = '0;
        next_cs = cs;
        // enable crosses into core_clk through two flops
        next_cs.enMeta = link.txnEn;
        next_cs.enSync = cs.enMeta;
        next_cs.enPrev = cs.enSync;
        // the apply pulse lasts one core cycle
        next_cs.applyPulse = 1'b0;
        endOfTxn = cs.enPrev & ~cs.enSync;
        if (endOfTxn) begin
            next_cs.applyPulse = 1'b1;
            // all six fields decode in the apply cycle
            // six fields of one register
            for (int p = 0; p < SWL_POTS; p++) begin
                // each pot reads its own field
                f = fieldOf(lk.shiftReg, p);
                if (isKeep(f)) begin
                    next_cs.keptMask[p] = 1'b1;
                end else begin
                    next_cs.keptMask[p] = 1'b0;
                    // low six bits are the position
                    next_cs.wiperPos[p] = f[SWL_POS_W-1:0];
                end
            end
            // a frame that is not a whole 48 bits moves the count
            next_cs.partialTxn = lk.bitCnt != cs.lastCnt;
            next_cs.lastCnt = lk.bitCnt;
        end
    end

    // core registers; wipers start at the low end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cs <= '0;
        end else begin
            cs <= next_cs;
        end
    end

    // outputs come straight from the core registers
    // wipers hold while bits shift
    assign wiperPos = cs.wiperPos;
    // frame status, then port activity
    assign applyPulse = cs.applyPulse;
    assign keptMask = cs.keptMask;
    assign partialTxn = cs.partialTxn;
    assign txnActive = cs.enSync;

endmodule // swl_device

// ==== rtl/swl_host.sv ====
// controller end: APB registers driving the three-wire link
//
// Added by the designer: the placing of the registers and the APB slave port.
module swl_host
    import swl_pkg::*;
#(
    parameter int HALF_CYC = SWL_HALF_CYC
)
(
    // core clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link to the device
    swl_link_if.host link
);

    localparam logic [7:0] HALF = 8'(HALF_CYC);

    typedef struct packed {
        swl_host_e state;
        logic readMode;
        logic [SWL_SR_W-1:0] txWord;
        logic [SWL_SR_W-1:0] rxWord;
        logic [5:0] bitIdx;
        logic [7:0] waitCnt;
        logic casMeta;
        logic casSync;
        logic txnEn;
        logic shiftClk;
        logic dataOut;
        logic dataOeN;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } swl_host_s;

    swl_host_s hs;
    swl_host_s next_hs;

    // register read mux; bit 32 flags an unmapped offset
    function automatic logic [32:0] readReg(
        input logic [7:0] a,
        input swl_host_s s
    );
        case (a)
            SWL_REG_CTRL: readReg = {31'h0, s.readMode, 1'b0};
            SWL_REG_STATUS: readReg = {32'h0, s.state != SWL_IDLE};
            SWL_REG_TXLO: readReg = {1'b0, s.txWord[31:0]};
            SWL_REG_TXHI: readReg = {17'h0, s.txWord[47:32]};
            SWL_REG_RXLO: readReg = {1'b0, s.rxWord[31:0]};
            SWL_REG_RXHI: readReg = {17'h0, s.rxWord[47:32]};
            default: readReg = {1'b1, 32'h0};
        endcase
    endfunction

    always_comb begin
        logic startReq;
        logic [32:0] rd;
        startReq = 1'b0;
        rd = readReg(paddr, hs);
        next_hs = hs;
        // cascade passes two flops before use
        next_hs.casMeta = link.cascade;
        next_hs.casSync = hs.casMeta;
        // answer in the cycle after setup
        next_hs.pready = 1'b0;
        next_hs.pslverr = 1'b0;
        if (psel && !penable) begin
            next_hs.pready = 1'b1;
            next_hs.prdata = rd[31:0];
            next_hs.pslverr = rd[32];
        end
        // writes land on the completing access edge
        if (psel && penable && hs.pready && pwrite) begin
            case (paddr)
                SWL_REG_CTRL: begin
                    next_hs.readMode = pwdata[SWL_CTRL_READ];
                    startReq = pwdata[SWL_CTRL_START];
                end
                SWL_REG_TXLO: next_hs.txWord[31:0] = pwdata;
                SWL_REG_TXHI: next_hs.txWord[47:32] = pwdata[15:0];
                default: startReq = 1'b0;
            endcase
            // no new frame or data change while a frame runs
            if (hs.state != SWL_IDLE) begin
                startReq = 1'b0;
                next_hs.txWord = hs.txWord;
                next_hs.readMode = hs.readMode;
            end
        end
        // frame sequencer
        case (hs.state)
            SWL_IDLE: begin
                if (startReq) begin
                    next_hs.txnEn = 1'b1;
                    next_hs.shiftClk = 1'b0;
                    // lsb of pot 1 goes first
                    next_hs.dataOut = next_hs.txWord[0];
                    // read mode releases data to feedback
                    next_hs.dataOeN = next_hs.readMode;
                    next_hs.bitIdx = '0;
                    next_hs.waitCnt = SWL_CC_CYC - 8'h01;
                    next_hs.state = SWL_ENSETUP;
                end
            end
            SWL_ENSETUP, SWL_CLKLOW: begin
                if (hs.waitCnt != 8'h00) begin
                    next_hs.waitCnt = hs.waitCnt - 8'h01;
                end else begin
                    next_hs.shiftClk = 1'b1;
                    // capture the bit the device shows before it shifts
                    next_hs.rxWord = {hs.casSync, hs.rxWord[SWL_SR_W-1:1]};
                    next_hs.waitCnt = HALF - 8'h01;
                    next_hs.state = SWL_CLKHIGH;
                end
            end
            SWL_CLKHIGH: begin
                if (hs.waitCnt != 8'h00) begin
                    next_hs.waitCnt = hs.waitCnt - 8'h01;
                end else begin
                    next_hs.shiftClk = 1'b0;
                    if (hs.bitIdx == SWL_LAST_BIT) begin
                        next_hs.waitCnt = SWL_HLT_CYC - 8'h01;
                        next_hs.state = SWL_ENDHOLD;
                    end else begin
                        next_hs.bitIdx = hs.bitIdx + SWL_CNT_ONE;
                        next_hs.dataOut = hs.txWord[next_hs.bitIdx];
                        next_hs.waitCnt = HALF - 8'h01;
                        next_hs.state = SWL_CLKLOW;
                    end
                end
            end
            SWL_ENDHOLD: begin
                if (hs.waitCnt != 8'h00) begin
                    next_hs.waitCnt = hs.waitCnt - 8'h01;
                end else begin
                    // enable falls to end the frame
                    next_hs.txnEn = 1'b0;
                    next_hs.dataOeN = 1'b1;
                    next_hs.waitCnt = SWL_RLT_CYC - 8'h01;
                    next_hs.state = SWL_RECOVER;
                end
            end
            SWL_RECOVER: begin
                if (hs.waitCnt != 8'h00) begin
                    next_hs.waitCnt = hs.waitCnt - 8'h01;
                end else begin
                    next_hs.state = SWL_IDLE;
                end
            end
            default: next_hs.state = SWL_IDLE;
        endcase
    end

    // data line starts released so the feedback path rules it
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hs <= '0;
            hs.dataOeN <= 1'b1;
        end else begin
            hs <= next_hs;
        end
    end

    assign prdata = hs.prdata;
    assign pready = hs.pready;
    assign pslverr = hs.pslverr;
    assign link.txnEn = hs.txnEn;
    assign link.shiftClk = hs.shiftClk;
    assign link.hostData = hs.dataOut;
    assign link.hostDataOeN = hs.dataOeN;

endmodule // swl_host

// ==== tb/swl_link_props.sv ====
// concurrent checks on the three-wire link between controller and device
module swl_link_props (
    // core clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // link wires
    input wire logic txnEn,
    input wire logic shiftClk,
    input wire logic hostData,
    input wire logic hostDataOeN,
    input wire logic cascade,
    input wire logic serData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prevClk;
    logic [7:0] riseCnt;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // shift clock rises seen in the current frame, cleared when idle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prevClk <= 1'b0;
            riseCnt <= 8'h00;
        end else begin
            prevClk <= shiftClk;
            if (!txnEn) begin
                riseCnt <= 8'h00;
            end else if (shiftClk && !prevClk) begin
                riseCnt <= riseCnt + 8'h01;
            end
        end
    end

    property p_clk_idle; !txnEn |-> !shiftClk; endproperty
    property p_lead; $rose(txnEn) |-> !shiftClk [*2]; endproperty
    property p_half;
        $rose(shiftClk) |-> shiftClk [*4] ##1 !shiftClk;
    endproperty
    property p_data_hold;
        $rose(shiftClk) && !hostDataOeN |-> $stable(hostData);
    endproperty
    property p_cas_step;
        $changed(cascade) |-> txnEn && $rose(shiftClk);
    endproperty
    property p_full; $fell(txnEn) |-> riseCnt == 8'h30; endproperty
    property p_recover; $fell(txnEn) |-> !txnEn [*4]; endproperty
    property p_release; !txnEn |-> hostDataOeN; endproperty

    a_clk_idle: assert property (p_clk_idle)
        else $error("shift clock high while port idle");
    a_lead: assert property (p_lead)
        else $error("shift clock too soon after enable rise");
    a_half: assert property (p_half)
        else $error("shift clock high phase wrong length");
    a_data_hold: assert property (p_data_hold)
        else $error("data moved at shift clock rise");
    a_cas_step: assert property (p_cas_step)
        else $error("cascade moved without accepted clock");
    a_full: assert property (p_full)
        else $error("frame did not carry 48 clocks");
    a_recover: assert property (p_recover)
        else $error("enable low time too short");
    a_release: assert property (p_release)
        else $error("data line driven outside frame");

    // main traffic kinds
    c_write: cover property ($rose(txnEn) && !hostDataOeN);
    c_read: cover property ($rose(txnEn) && hostDataOeN && serData == cascade);
    c_end: cover property ($fell(txnEn));
endmodule // swl_link_props

// ==== tb/tb_sextet_wiper_serial_loader.sv ====
// testbench: controller and device joined by the link, driven over APB
module tb_sextet_wiper_serial_loader
    import swl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [47:0] tx;
        logic [35:0] pos;
        logic [5:0] kept;
    } swl_row_s;
    // frame word beside the wipers and keep mask it should leave
    localparam swl_row_s ROWS [4] = '{
        '{48'h3F2A150F0100, {6'h3F, 6'h2A, 6'h15, 6'h0F, 6'h01, 6'h00}, 6'h00},
        '{48'h7F00FF47BEC5, {6'h3F, 6'h00, 6'h15, 6'h07, 6'h3E, 6'h00}, 6'h09},
        '{48'hFFFFFFFFFFFF, {6'h3F, 6'h00, 6'h15, 6'h07, 6'h3E, 6'h00}, 6'h3F},
        '{48'hC0000000003F, {6'h3F, 6'h00, 6'h00, 6'h00, 6'h00, 6'h3F}, 6'h20}};
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic pready, pslverr, applyPulse, partialTxn, txnAct, e;
    logic [SWL_POTS-1:0][SWL_POS_W-1:0] wiperPos;
    logic [SWL_POTS-1:0] keptMask;
    logic [47:0] lastTx, rx;
    logic [35:0] lastPos;
    int failures = 0;
    int checkCount = 0;
    int applies = 0;

    swl_link_if link();
    swl_host swl_host_i (.core_clk(core_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    swl_device swl_device_i (.core_clk(core_clk), .nrst(nrst), .link(link),
        .wiperPos(wiperPos), .applyPulse(applyPulse), .keptMask(keptMask),
        .partialTxn(partialTxn), .txnActive(txnAct));
    swl_link_props swl_link_props_i (.core_clk(core_clk), .nrst(nrst),
        .txnEn(link.txnEn), .shiftClk(link.shiftClk),
        .hostData(link.hostData), .hostDataOeN(link.hostDataOeN),
        .cascade(link.cascade), .serData(link.serData));

    always #20 core_clk = ~core_clk;
    // apply pulses, one expected per frame
    always @(posedge core_clk) if (applyPulse === 1'b1) applies++;

    task automatic chk_pos(input logic [35:0] got, input logic [35:0] exp);
        checkCount++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t wipers %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [47:0] got, input logic [47:0] exp);
        checkCount++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t value %h exp %h", $time, got, exp);
        end
    endtask
    // one APB transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic er);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // no wait-state limit here: only the watchdog ends a stuck wait
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    // load, start, and watch wipers hold while the enable is up
    task automatic frame(input logic [47:0] tx, input logic rd,
        input logic [35:0] hold);
        logic seen;
        seen = 1'b0;
        apb(1'b1, SWL_REG_TXLO, tx[31:0], r, e);
        apb(1'b1, SWL_REG_TXHI, {16'h0000, tx[47:32]}, r, e);
        apb(1'b1, SWL_REG_CTRL, {30'h0000_0000, rd, 1'b1}, r, e);
        do begin
            apb(1'b0, SWL_REG_STATUS, 32'h0000_0000, r, e);
            // wipers may move once the enable is down, while still busy
            if (r[0] === 1'b1 && link.txnEn === 1'b1) begin
                chk_pos(wiperPos, hold);
            end
            if (txnAct === 1'b1) seen = 1'b1;
        end while (r[0] !== 1'b0);
        repeat (4) @(posedge core_clk);
        chk_word({47'h0, seen}, 48'h1);
        chk_word({47'h0, txnAct}, 48'h0);
    endtask
    task automatic rxread(output logic [47:0] v);
        logic [31:0] lo;
        apb(1'b0, SWL_REG_RXLO, 32'h0000_0000, lo, e);
        apb(1'b0, SWL_REG_RXHI, 32'h0000_0000, r, e);
        v = {r[15:0], lo};
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", checkCount, failures);
        if (failures == 0 && checkCount > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // a hang costs far more than all frames together
    initial begin
        #2_000_000;
        failures++;
        finish_test();
    end

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        lastTx = 48'h0000_0000_0000;
        lastPos = 36'h0_0000_0000;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        chk_pos(wiperPos, 36'h0_0000_0000);
        chk_word({47'h0, link.cascade}, 48'h0);
        chk_word({47'h0, txnAct}, 48'h0);
        // ordinary write frames; each sees the previous word on cascade
        foreach (ROWS[i]) begin
            frame(ROWS[i].tx, 1'b0, lastPos);
            chk_pos(wiperPos, ROWS[i].pos);
            chk_word({42'h0, keptMask}, {42'h0, ROWS[i].kept});
            rxread(rx);
            chk_word(rx, lastTx);
            lastTx = ROWS[i].tx;
            lastPos = ROWS[i].pos;
        end
        // two recirculating reads leave contents and wipers alone
        repeat (2) begin
            frame(48'h0000_0000_0000, 1'b1, lastPos);
            chk_pos(wiperPos, lastPos);
            rxread(rx);
            chk_word(rx, lastTx);
        end
        chk_word({47'h0, partialTxn}, 48'h0);
        chk_word(48'(applies), 48'h6);
        // unmapped offset answers with an error and zero data
        apb(1'b0, 8'h20, 32'h0000_0000, r, e);
        chk_word({15'h0, e, r}, {15'h0, 1'b1, 32'h0});
        // reset in mid-run puts every wiper back at the low end
        nrst <= 1'b0;
        @(posedge core_clk);
        chk_pos(wiperPos, 36'h0_0000_0000);
        nrst <= 1'b1;
        // the shift register came back empty and a write still lands
        frame(ROWS[0].tx, 1'b0, 36'h0_0000_0000);
        chk_pos(wiperPos, ROWS[0].pos);
        rxread(rx);
        chk_word(rx, 48'h0);
        finish_test();
    end
endmodule // tb_sextet_wiper_serial_loader
